// file: verilog/black_cal_pkg.sv
// Constants and state layout for the black level calibration controller.
package black_cal_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_FILTER_CTRL = 16'h4000;
  localparam logic [15:0] IDX_FIRST_ROW = 16'h4001;
  localparam logic [15:0] IDX_AUTO_TRIG = 16'h4002;
  localparam logic [15:0] IDX_MAN_TRIG = 16'h4003;
  localparam logic [15:0] IDX_ROW_COUNT = 16'h4004;
  localparam logic [15:0] IDX_POLICY = 16'h4005;
  localparam logic [15:0] IDX_GAIN_TRIG = 16'h4007;
  localparam logic [15:0] IDX_TARGET_HI = 16'h4008;
  localparam logic [15:0] IDX_TARGET_LO = 16'h4009;
  localparam logic [15:0] IDX_FIXED_HI = 16'h400C;
  localparam logic [15:0] IDX_FIXED_LO = 16'h400D;
  localparam logic [15:0] IDX_THRESH = 16'h401D;
  localparam logic [15:0] IDX_DEBUG = 16'h401E;
  localparam logic [15:0] IDX_STATUS = 16'h4020;
  localparam logic [15:0] IDX_LEVEL_HI = 16'h4021;
  localparam logic [15:0] IDX_LEVEL_LO = 16'h4022;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FILTER_CTRL = 8'h0C;
  localparam logic [7:0] RST_FIRST_ROW = 8'h04;
  localparam logic [7:0] RST_AUTO_TRIG = 8'h45;
  localparam logic [7:0] RST_MAN_TRIG = 8'h01;
  localparam logic [7:0] RST_ROW_COUNT = 8'h08;
  localparam logic [7:0] RST_POLICY = 8'h40;
  localparam logic [7:0] RST_GAIN_TRIG = 8'h20;
  localparam logic [7:0] RST_TARGET_HI = 8'h00;
  localparam logic [7:0] RST_TARGET_LO = 8'h40;
  localparam logic [7:0] RST_FIXED = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h7F;
  localparam logic [7:0] RST_DEBUG = 8'h80;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_MEDIAN_EN = 1;
  localparam int BIT_FORMAT_EN = 7;
  localparam int BIT_AUTO_SEL = 6;
  localparam int BIT_MAN_TRIG = 7;
  localparam int BIT_HOLD = 6;
  localparam int BIT_ALWAYS_UPD = 1;
  localparam int BIT_GAIN_EN = 5;
  localparam logic [5:0] GAIN_FRAMES = 6'h01;
  // ----------------------------------------------------------------
  // Whole state of the controller
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] filter_ctrl;
    logic [7:0] first_row;
    logic [7:0] auto_trig;
    logic [7:0] man_trig;
    logic [7:0] row_count;
    logic [7:0] policy;
    logic [7:0] gain_trig;
    logic [7:0] target_hi;
    logic [7:0] target_lo;
    logic [7:0] fixed_hi;
    logic [7:0] fixed_lo;
    logic [7:0] thresh;
    logic [7:0] debug;
    logic [5:0] frames_left;
    logic init_pending;
    logic [15:0] hist1;
    logic [15:0] hist2;
    logic [15:0] applied;
    logic [15:0] level_out;
    logic [15:0] target_out;
    logic active;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cal_state_t;
endpackage

// file: verilog/black_level_calibration_ctrl.sv
// Black level calibration controller with an APB register slave.
`timescale 1ns/1ps
module black_level_calibration_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_start,
  input wire logic format_change,
  input wire logic gain_change,
  input wire logic sample_valid,
  input wire logic [15:0] sample_level,
  output logic [15:0] black_level,
  output logic [15:0] black_target_value,
  output logic cal_active
);
  import black_cal_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] med3(input logic [15:0] a,
                                       input logic [15:0] b,
                                       input logic [15:0] c);
    logic [15:0] m;
    m = a;
    if ((a >= b && a <= c) || (a <= b && a >= c)) begin
      m = a;
    end else if ((b >= a && b <= c) || (b <= a && b >= c)) begin
      m = b;
    end else begin
      m = c;
    end
    return m;
  endfunction

  cal_state_t state_reg;
  cal_state_t state_next;

  logic [15:0] idx;
  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_val;
  logic [15:0] filtered;
  logic [15:0] diff;
  logic drift;
  logic always_upd;
  logic frozen;
  logic do_update;
  logic man_fire;

  assign idx = paddr[17:2];
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & state_reg.pready;
  assign wr_en = access_done & pwrite & ~state_reg.pslverr;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (idx)
      IDX_FILTER_CTRL: rd_val[7:0] = state_reg.filter_ctrl;
      IDX_FIRST_ROW: rd_val[7:0] = state_reg.first_row;
      IDX_AUTO_TRIG: rd_val[7:0] = state_reg.auto_trig;
      IDX_MAN_TRIG: rd_val[7:0] = state_reg.man_trig;
      IDX_ROW_COUNT: rd_val[7:0] = state_reg.row_count;
      IDX_POLICY: rd_val[7:0] = state_reg.policy;
      IDX_GAIN_TRIG: rd_val[7:0] = state_reg.gain_trig;
      IDX_TARGET_HI: rd_val[7:0] = state_reg.target_hi;
      IDX_TARGET_LO: rd_val[7:0] = state_reg.target_lo;
      IDX_FIXED_HI: rd_val[7:0] = state_reg.fixed_hi;
      IDX_FIXED_LO: rd_val[7:0] = state_reg.fixed_lo;
      IDX_THRESH: rd_val[7:0] = state_reg.thresh;
      IDX_DEBUG: rd_val[7:0] = state_reg.debug;
      IDX_STATUS: rd_val[7:0] = {state_reg.active, frozen,
                                 state_reg.frames_left};
      IDX_LEVEL_HI: rd_val[7:0] = state_reg.applied[15:8];
      IDX_LEVEL_LO: rd_val[7:0] = state_reg.applied[7:0];
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Calibration datapath
  // ----------------------------------------------------------------
  always_comb begin
    filtered = sample_level;
    if (state_reg.filter_ctrl[BIT_MEDIAN_EN]) begin
      filtered = med3(sample_level, state_reg.hist1, state_reg.hist2);
    end
    if (filtered >= state_reg.applied) begin
      diff = filtered - state_reg.applied;
    end else begin
      diff = state_reg.applied - filtered;
    end
    drift = diff > {8'h00, state_reg.thresh};
    always_upd = state_reg.policy[BIT_ALWAYS_UPD];
    frozen = state_reg.man_trig[BIT_HOLD] & ~always_upd;
    do_update = sample_valid & ~frozen &
                (always_upd | (state_reg.frames_left != 6'h00) | drift);
    man_fire = wr_en & (idx == IDX_MAN_TRIG) & pwdata[BIT_MAN_TRIG];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.init_pending = 1'b0;

    // Frame count: a trigger wins over the per-frame decrement.
    if (frame_start && state_reg.frames_left != 6'h00) begin
      state_next.frames_left = state_reg.frames_left - 6'h01;
    end
    if (gain_change && state_reg.gain_trig[BIT_GAIN_EN]) begin
      state_next.frames_left = GAIN_FRAMES;
    end
    if (state_reg.init_pending ||
        (format_change && state_reg.auto_trig[BIT_FORMAT_EN])) begin
      state_next.frames_left = state_reg.auto_trig[5:0];
    end
    if (man_fire) begin
      state_next.frames_left = pwdata[5:0];
    end

    if (sample_valid) begin
      state_next.hist2 = state_reg.hist1;
      state_next.hist1 = sample_level;
    end
    if (do_update) begin
      state_next.applied = filtered;
    end
    state_next.active = ~frozen &
                        (always_upd | (state_reg.frames_left != 6'h00));

    if (state_reg.auto_trig[BIT_AUTO_SEL]) begin
      state_next.level_out = state_reg.applied;
    end else begin
      state_next.level_out = {state_reg.fixed_hi, state_reg.fixed_lo};
    end
    state_next.target_out = {state_reg.target_hi, state_reg.target_lo};

    // APB: answer one cycle after setup, zero wait in access.
    state_next.pready = 1'b0;
    if (setup_phase) begin
      state_next.pready = 1'b1;
      state_next.pslverr = ~mapped;
      state_next.prdata = pwrite ? 32'h0000_0000 : rd_val;
    end else if (access_done) begin
      state_next.pslverr = 1'b0;
    end

    if (wr_en) begin
      unique case (idx)
        IDX_FILTER_CTRL: state_next.filter_ctrl = pwdata[7:0];
        IDX_FIRST_ROW: state_next.first_row = pwdata[7:0];
        IDX_AUTO_TRIG: state_next.auto_trig = pwdata[7:0];
        IDX_MAN_TRIG: state_next.man_trig = pwdata[7:0];
        IDX_ROW_COUNT: state_next.row_count = pwdata[7:0];
        IDX_POLICY: state_next.policy = pwdata[7:0];
        IDX_GAIN_TRIG: state_next.gain_trig = pwdata[7:0];
        IDX_TARGET_HI: state_next.target_hi = pwdata[7:0];
        IDX_TARGET_LO: state_next.target_lo = pwdata[7:0];
        IDX_FIXED_HI: state_next.fixed_hi = pwdata[7:0];
        IDX_FIXED_LO: state_next.fixed_lo = pwdata[7:0];
        IDX_THRESH: state_next.thresh = pwdata[7:0];
        IDX_DEBUG: state_next.debug = pwdata[7:0];
        default: state_next.debug = state_reg.debug;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.filter_ctrl <= RST_FILTER_CTRL;
      state_reg.first_row <= RST_FIRST_ROW;
      state_reg.auto_trig <= RST_AUTO_TRIG;
      state_reg.man_trig <= RST_MAN_TRIG;
      state_reg.row_count <= RST_ROW_COUNT;
      state_reg.policy <= RST_POLICY;
      state_reg.gain_trig <= RST_GAIN_TRIG;
      state_reg.target_hi <= RST_TARGET_HI;
      state_reg.target_lo <= RST_TARGET_LO;
      state_reg.fixed_hi <= RST_FIXED;
      state_reg.fixed_lo <= RST_FIXED;
      state_reg.thresh <= RST_THRESH;
      state_reg.debug <= RST_DEBUG;
      state_reg.frames_left <= 6'h00;
      state_reg.init_pending <= 1'b1;
      state_reg.hist1 <= 16'h0000;
      state_reg.hist2 <= 16'h0000;
      state_reg.applied <= 16'h0000;
      state_reg.level_out <= 16'h0000;
      state_reg.target_out <= {RST_TARGET_HI, RST_TARGET_LO};
      state_reg.active <= 1'b0;
      state_reg.prdata <= 32'h0000_0000;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign black_level = state_reg.level_out;
  assign black_target_value = state_reg.target_out;
  assign cal_active = state_reg.active;
endmodule

// file: sim/black_cal_monitor.sv
// Port checker for the black level calibration controller.
`timescale 1ns/1ps
module black_cal_monitor
  import black_cal_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_valid,
  input wire logic [15:0] sample_level,
  input wire logic [15:0] black_level,
  input wire logic [15:0] black_target_value,
  input wire logic cal_active
);
  logic wr, hold_sh, pol_sh, auto_sh, med_sh;
  logic [15:0] idx;
  assign idx = paddr[17:2];
  assign wr = psel && penable && pready && pwrite;
  // Shadow copies of the control bits, tracked from completed writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_sh <= RST_MAN_TRIG[BIT_HOLD];
      pol_sh <= RST_POLICY[BIT_ALWAYS_UPD];
      auto_sh <= RST_AUTO_TRIG[BIT_AUTO_SEL];
      med_sh <= RST_FILTER_CTRL[BIT_MEDIAN_EN];
    end else if (wr) begin
      if (idx == IDX_MAN_TRIG) hold_sh <= pwdata[BIT_HOLD];
      if (idx == IDX_POLICY) pol_sh <= pwdata[BIT_ALWAYS_UPD];
      if (idx == IDX_AUTO_TRIG) auto_sh <= pwdata[BIT_AUTO_SEL];
      if (idx == IDX_FILTER_CTRL) med_sh <= pwdata[BIT_MEDIAN_EN];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (psel && !penable && idx == 16'h4006
    |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_target_lo_out: assert property (wr && idx == IDX_TARGET_LO |->
    ##2 black_target_value[7:0] == $past(pwdata[7:0], 2))
    else $error("target low byte not shown");
  a_hold_freezes: assert property (hold_sh && !pol_sh |=> !cal_active)
    else $error("active while frozen");
  a_always_update: assert property (pol_sh |=> cal_active)
    else $error("inactive with always update");
  // The active flag one cycle after a sample is set only if the very state
  // that took the sample allowed its update; a drift can update while it is clear.
  a_sample_applied: assert property (
    sample_valid && auto_sh && !med_sh ##1 cal_active && auto_sh
    |-> ##1 black_level == $past(sample_level, 2))
    else $error("sample not applied");
  a_active_at_start: assert property (
    $rose(presetn) |-> ##2 cal_active)
    else $error("no calibration after reset");
  cover property (wr && idx == IDX_TARGET_LO);
  cover property (sample_valid && cal_active);
  cover property (pslverr);
endmodule
bind black_level_calibration_ctrl black_cal_monitor u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sample_valid(sample_valid),
  .sample_level(sample_level), .black_level(black_level),
  .black_target_value(black_target_value), .cal_active(cal_active));

// file: sim/tb_top.sv
// Self-checking bench for the black level calibration controller.
`timescale 1ns/1ps
module tb_top;
  import black_cal_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [2:0] ev = 0;
  logic sample_valid = 0, pready, pslverr, cal_active, err;
  logic [15:0] sample_level = 0, black_level, black_target_value;
  logic [15:0] ri [12] = '{IDX_FILTER_CTRL, IDX_FIRST_ROW, IDX_AUTO_TRIG,
    IDX_MAN_TRIG, IDX_ROW_COUNT, IDX_POLICY, IDX_GAIN_TRIG, IDX_TARGET_HI,
    IDX_TARGET_LO, IDX_FIXED_HI, IDX_THRESH, IDX_DEBUG};
  logic [7:0] rv [12] = '{8'h0C, 8'h04, 8'h45, 8'h01, 8'h08, 8'h40, 8'h20,
    8'h00, 8'h40, 8'h00, 8'h7F, 8'h80};
  int n_fail = 0;
  int samples_checked = 0;
  always #20 pclk = ~pclk;
  black_level_calibration_ctrl u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(ev[0]), .format_change(ev[1]), .gain_change(ev[2]),
    .sample_valid(sample_valid), .sample_level(sample_level),
    .black_level(black_level), .black_target_value(black_target_value),
    .cal_active(cal_active));
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [15:0] i,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task automatic st(input logic [7:0] e);
    repeat (2) @(posedge pclk);
    rdc(IDX_STATUS, e);
  endtask
  task automatic pulse(input logic [2:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 3'h0;
    @(posedge pclk);
  endtask
  task automatic samp(input logic [15:0] v);
    sample_level <= v;
    sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ri[k]) rdc(ri[k], rv[k]);
    chk({16'h0, black_target_value}, 32'h40);
    st(8'h85);
    apb(1'b0, 16'h4006, 8'h00);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, IDX_TARGET_HI, 8'hA5);
    apb(1'b1, IDX_TARGET_LO, 8'h3C);
    repeat (2) @(posedge pclk);
    chk({16'h0, black_target_value}, 32'hA53C);
    samp(16'h0123);
    chk({16'h0, black_level}, 32'h123);
    apb(1'b1, IDX_FILTER_CTRL, 8'h0E);
    samp(16'h0200);
    samp(16'h0100);
    samp(16'h0300);
    chk({16'h0, black_level}, 32'h200);
    apb(1'b1, IDX_FILTER_CTRL, 8'h0C);
    repeat (5) pulse(3'h1);
    st(8'h00);
    samp(16'h0400);
    chk({16'h0, black_level}, 32'h400);
    samp(16'h0410);
    chk({16'h0, black_level}, 32'h400);
    apb(1'b1, IDX_MAN_TRIG, 8'h83);
    st(8'h83);
    repeat (3) pulse(3'h1);
    pulse(3'h4);
    st(8'h81);
    pulse(3'h2);
    st(8'h81);
    apb(1'b1, IDX_AUTO_TRIG, 8'hC7);
    pulse(3'h2);
    st(8'h87);
    apb(1'b1, IDX_MAN_TRIG, 8'h40);
    st(8'h47);
    samp(16'h0100);
    chk({16'h0, black_level}, 32'h400);
    apb(1'b1, IDX_POLICY, 8'h42);
    st(8'h87);
    samp(16'h0100);
    chk({16'h0, black_level}, 32'h100);
    apb(1'b1, IDX_FIXED_HI, 8'h12);
    apb(1'b1, IDX_FIXED_LO, 8'h34);
    apb(1'b1, IDX_AUTO_TRIG, 8'h07);
    repeat (2) @(posedge pclk);
    chk({16'h0, black_level}, 32'h1234);
    results();
  end
  initial begin
    #400000;
    n_fail++;
    results();
  end
endmodule
